// ---- rtl/dtblc_regs.svh ----
`ifndef DTBLC_REGS_SVH
`define DTBLC_REGS_SVH
// ****************************************
// instruction classes, instr[31:28]
// ****************************************
`define DTBLC_CL_NOP    4'h0
`define DTBLC_CL_LDST   4'h1
`define DTBLC_CL_TRANS  4'h2
`define DTBLC_CL_IMM    4'h3
`define DTBLC_CL_JMP    4'h4
`define DTBLC_CL_CALL   4'h5
`define DTBLC_CL_RET    4'h6
`define DTBLC_CL_IRET   4'h7
`define DTBLC_CL_REP    4'h8
`define DTBLC_CL_LOOP   4'h9
`define DTBLC_CL_LOOP_STACK_POP   4'hA
`define DTBLC_CL_HALT   4'hB
`define DTBLC_CL_DISCARD_PENDING_INTERRUPT   4'hC
`define DTBLC_CL_IEN    4'hD
// ****************************************
// field positions
// ****************************************
`define DTBLC_X_LSB     13
`define DTBLC_SIDE_W    13
// ****************************************
// register part codes
// ****************************************
`define DTBLC_PT_WHOLE  3'h0
`define DTBLC_PT_EXTHI  3'h1
`define DTBLC_PT_EXT    3'h2
`define DTBLC_PT_HI     3'h3
`define DTBLC_PT_LO     3'h4
// ****************************************
// pointer modification codes
// ****************************************
`define DTBLC_MD_NONE   3'h0
`define DTBLC_MD_INC    3'h1
`define DTBLC_MD_DEC    3'h2
`define DTBLC_MD_ADD    3'h3
`define DTBLC_MD_MOD    3'h4
`define DTBLC_MD_BREV   3'h5
// ****************************************
// immediate targets and non-general selectors
// ****************************************
`define DTBLC_IT_RL     2'h0
`define DTBLC_IT_DP     2'h1
`define DTBLC_IT_DN     2'h2
`define DTBLC_IT_DM     2'h3
`define DTBLC_NG_DN     5'h08
`define DTBLC_NG_DM     5'h10
`define DTBLC_NG_RC     5'h12
`define DTBLC_NG_LC     5'h13
// ****************************************
// reset values
// ****************************************
`define DTBLC_RST_PC    16'h0000
`define DTBLC_RST_DM    16'hFFFF
`endif

// ---- rtl/dtblc_pkg.sv ----
package dtblc_pkg;
	typedef enum logic [1:0] {
		DTBLC_RUN  = 2'h0,
		DTBLC_LOAD = 2'h1,
		DTBLC_HALT = 2'h3
	} dtblc_state_t;
	typedef logic [15:0] dtblc_word_t;
endpackage

// ---- rtl/dtblc_ptr_mod.sv ----
`timescale 1ns/1ps
`include "dtblc_regs.svh"
module dtblc_ptr_mod #(
	parameter int AW = 16
) (
	input  wire logic [AW-1:0] dp,
	input  wire logic [AW-1:0] dn,
	input  wire logic [AW-1:0] dm,
	input  wire logic [2:0]    mode,
	output logic      [AW-1:0] acc_addr,
	output logic      [AW-1:0] dp_next
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [AW-1:0] span(input logic [AW-1:0] v);
		logic [AW-1:0] m;
		m = v;
		for (int i = 1; i < AW; i++) begin
			m = m | (m >> 1);
		end
		return m;
	endfunction

	function automatic logic [AW-1:0] brev(input logic [AW-1:0] v);
		logic [AW-1:0] r;
		r = '0;
		for (int i = 0; i < AW; i++) begin
			r[i] = v[AW-1-i];
		end
		return r;
	endfunction

	logic [AW-1:0] mask;
	logic [AW:0]   lsum;
	logic [AW:0]   lim;
	logic [AW:0]   wrap;

	always_comb begin
		mask = span(dm);
		lsum = {1'b0, dp & mask} + {1'b0, dn};
		lim  = {1'b0, dm} + {{AW{1'b0}}, 1'b1};
		// single subtract: step must not exceed range
		wrap = (lsum >= lim) ? (lsum - lim) : lsum;
		acc_addr = dp;
		dp_next  = dp;
		case (mode)
			`DTBLC_MD_INC:  dp_next = dp + {{(AW-1){1'b0}}, 1'b1};
			`DTBLC_MD_DEC:  dp_next = dp - {{(AW-1){1'b0}}, 1'b1};
			`DTBLC_MD_ADD:  dp_next = dp + dn;
			`DTBLC_MD_MOD:  dp_next = (dp & ~mask) | wrap[AW-1:0];
			`DTBLC_MD_BREV: begin
				acc_addr = brev(dp);
				dp_next  = dp + dn;
			end
			default:        dp_next = dp;
		endcase
	end
endmodule // dtblc_ptr_mod

// ---- rtl/dtblc_core.sv ----
// Overview of operation
// - one word carries an X transfer, a Y transfer, or both together.
// - memory access uses the old pointer; modification lands afterwards.
// - load to whole, ext+high, ext, high or low; store only ext, high, low.
// - transfer moves a low half to or from a non-general register only.
// - immediate 0..FFFF loads a low half, data pointer or modifier.
// - immediate to a modulo range register is refused when zero.
// - call bumps stack pointer, pushes next address, jumps; return pops.
// - interrupt return pops, drops stack pointer, restores interrupt enable.
// - repeat/loop load counter, clear done flag; at end decrement, advance, set flag.
// - pointer modes: none, inc, dec, add, modulo add, bit-reversed then add.
`timescale 1ns/1ps
`include "dtblc_regs.svh"
module dtblc_core
	import dtblc_pkg::*;
#(
	parameter int CSD = 16,
	parameter int LSD = 4
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [31:0] instr,
	input  wire logic        instr_valid,
	input  wire logic [39:0] gpr_x_rdata,
	input  wire logic [39:0] gpr_y_rdata,
	input  wire logic [15:0] x_rdata,
	input  wire logic [15:0] y_rdata,
	input  wire logic        irq_req,
	input  wire logic [15:0] irq_vec,
	output logic      [15:0] prog_addr,
	output logic      [15:0] x_addr,
	output logic             x_rd,
	output logic             x_wr,
	output logic      [15:0] x_wdata,
	output logic      [15:0] y_addr,
	output logic             y_rd,
	output logic             y_wr,
	output logic      [15:0] y_wdata,
	output logic             gx_we,
	output logic      [2:0]  gx_idx,
	output logic      [2:0]  gx_part,
	output logic      [39:0] gx_wdata,
	output logic             gy_we,
	output logic      [2:0]  gy_idx,
	output logic      [2:0]  gy_part,
	output logic      [39:0] gy_wdata,
	output logic             halted,
	output logic             irq_ack,
	output logic             discard_pending_interrupt,
	output logic             repeat_done_flag
);
	localparam int SPW = $clog2(CSD);
	localparam int LPW = $clog2(LSD) + 1;

	// ****************************************
	// data helpers
	// ****************************************
	function automatic logic [39:0] ld_word(input logic [2:0] pt, input dtblc_word_t d);
		case (pt)
			`DTBLC_PT_WHOLE, `DTBLC_PT_EXTHI: ld_word = {{8{d[15]}}, d, 16'h0000};
			`DTBLC_PT_EXT:                    ld_word = {d[7:0], 32'h0000_0000};
			`DTBLC_PT_HI:                     ld_word = {8'h00, d, 16'h0000};
			default:                          ld_word = {24'h00_0000, d};
		endcase
	endfunction

	function automatic dtblc_word_t st_half(input logic [2:0] pt, input logic [39:0] r);
		case (pt)
			`DTBLC_PT_EXT: st_half = {{8{r[39]}}, r[39:32]};
			`DTBLC_PT_HI:  st_half = r[31:16];
			default:       st_half = r[15:0];
		endcase
	endfunction

	// ****************************************
	// state
	// ****************************************
	dtblc_state_t st_q, st_d;
	dtblc_word_t  pc_q, pc_d, rc_q, rc_d, lc_q, lc_d, le_q, le_d, ls_q, ls_d;
	dtblc_word_t  stk_q [CSD], stk_d [CSD];
	logic [47:0]  lstk_q [LSD], lstk_d [LSD];
	dtblc_word_t  dp_q [8], dp_d [8], dn_q [8], dn_d [8], dm_q [2], dm_d [2];
	logic [SPW-1:0] sp_q, sp_d;
	logic [LPW-1:0] lsp_q, lsp_d;
	logic         ie_q, ie_d, sie_q, sie_d, rf_q, rf_d, ack_q, ack_d, discard_pending_interrupt_q, discard_pending_interrupt_d;
	dtblc_word_t  ma_q [2], ma_d [2], mwd_q [2], mwd_d [2];
	logic         mrd_q [2], mrd_d [2], mwr_q [2], mwr_d [2], gwe_q [2], gwe_d [2];
	logic [2:0]   gidx_q [2], gidx_d [2], gpart_q [2], gpart_d [2];
	logic [39:0]  gwd_q [2], gwd_d [2];

	logic [12:0]  fld [2];
	logic [2:0]   pidx [2];
	dtblc_word_t  acc [2], dpn [2];
	logic [3:0]   cls;
	logic         exec, take_irq, adv;
	dtblc_word_t  seq, imm, ngv;
	logic [4:0]   ngs;
	logic [2:0]   iidx;

	// ****************************************
	// decode
	// ****************************************
	always_comb begin
		fld[0]   = instr[`DTBLC_X_LSB +: `DTBLC_SIDE_W];
		fld[1]   = instr[0 +: `DTBLC_SIDE_W];
		pidx[0]  = {1'b0, fld[0][4:3]};
		pidx[1]  = {1'b1, fld[1][4:3]};
		cls      = instr[31:28];
		imm      = instr[15:0];
		iidx     = instr[25:23];
		ngs      = instr[23:19];
		seq      = pc_q + 16'h0001;
		take_irq = (st_q != DTBLC_LOAD) && irq_req && ie_q;
		exec     = (st_q == DTBLC_RUN) && instr_valid && !take_irq;
	end

	for (genvar s = 0; s < 2; s++) begin : g_pm
		dtblc_ptr_mod #(
			.AW       (16)
		) u_pm (
			.dp       (dp_q[pidx[s]]),
			.dn       (dn_q[pidx[s]]),
			.dm       (dm_q[s]),
			.mode     (fld[s][2:0]),
			.acc_addr (acc[s]),
			.dp_next  (dpn[s])
		);
	end

	// ****************************************
	// execute
	// ****************************************
	always_comb begin
		st_d = st_q; pc_d = pc_q; rc_d = rc_q; lc_d = lc_q; le_d = le_q; ls_d = ls_q;
		stk_d = stk_q; lstk_d = lstk_q; dp_d = dp_q; dn_d = dn_q; dm_d = dm_q;
		sp_d = sp_q; lsp_d = lsp_q; ie_d = ie_q; sie_d = sie_q; rf_d = rf_q;
		ack_d = 1'b0; discard_pending_interrupt_d = 1'b0; adv = 1'b1; ngv = 16'h0000;
		ma_d = ma_q; mwd_d = mwd_q; gidx_d = gidx_q; gpart_d = gpart_q; gwd_d = gwd_q;
		for (int s = 0; s < 2; s++) begin
			mrd_d[s] = 1'b0;
			mwr_d[s] = 1'b0;
			gwe_d[s] = 1'b0;
		end
		case (st_q)
			DTBLC_LOAD: begin
				// memory data is valid during the strobe cycle
				st_d     = DTBLC_RUN;
				gwe_d[0] = mrd_q[0];
				gwe_d[1] = mrd_q[1];
				gwd_d[0] = ld_word(gpart_q[0], x_rdata);
				gwd_d[1] = ld_word(gpart_q[1], y_rdata);
			end
			DTBLC_HALT: st_d = DTBLC_HALT;
			DTBLC_RUN: if (exec) begin
				case (cls)
					`DTBLC_CL_LDST: for (int s = 0; s < 2; s++) begin
						if (fld[s][12]) begin
							ma_d[s] = acc[s];
							dp_d[pidx[s]] = dpn[s];
							gidx_d[s] = fld[s][7:5];
							gpart_d[s] = fld[s][10:8];
							if (fld[s][11]) begin
								// whole and ext+high are not storable
								if (fld[s][10:8] >= `DTBLC_PT_EXT && fld[s][10:8] <= `DTBLC_PT_LO) begin
									mwr_d[s] = 1'b1;
									mwd_d[s] = st_half(fld[s][10:8], s == 0 ? gpr_x_rdata : gpr_y_rdata);
								end
							end else if (fld[s][10:8] <= `DTBLC_PT_LO) begin
								mrd_d[s] = 1'b1;
								st_d = DTBLC_LOAD;
							end
						end
					end
					`DTBLC_CL_TRANS: begin
						if (ngs < `DTBLC_NG_DN) ngv = dp_q[ngs[2:0]];
						else if (ngs < `DTBLC_NG_DM) ngv = dn_q[ngs[2:0]];
						else if (ngs < `DTBLC_NG_RC) ngv = dm_q[ngs[0]];
						else if (ngs == `DTBLC_NG_RC) ngv = rc_q;
						else ngv = lc_q;
						if (instr[27]) begin
							gwe_d[0] = 1'b1;
							gidx_d[0] = instr[26:24];
							gpart_d[0] = `DTBLC_PT_LO;
							gwd_d[0] = {24'h00_0000, ngv};
						end else if (ngs < `DTBLC_NG_DN) dp_d[ngs[2:0]] = gpr_x_rdata[15:0];
						else if (ngs < `DTBLC_NG_DM) dn_d[ngs[2:0]] = gpr_x_rdata[15:0];
						else if (ngs < `DTBLC_NG_RC) dm_d[ngs[0]] = gpr_x_rdata[15:0];
						else if (ngs == `DTBLC_NG_RC) rc_d = gpr_x_rdata[15:0];
						else if (ngs == `DTBLC_NG_LC) lc_d = gpr_x_rdata[15:0];
					end
					`DTBLC_CL_IMM: case (instr[27:26])
						`DTBLC_IT_RL: begin
							gwe_d[0] = 1'b1;
							gidx_d[0] = iidx;
							gpart_d[0] = `DTBLC_PT_LO;
							gwd_d[0] = {24'h00_0000, imm};
						end
						`DTBLC_IT_DP: dp_d[iidx] = imm;
						`DTBLC_IT_DN: dn_d[iidx] = imm;
						default: if (imm != 16'h0000) dm_d[iidx[0]] = imm;
					endcase
					`DTBLC_CL_JMP: begin
						adv = 1'b0;
						pc_d = instr[27] ? dp_q[instr[26:24]] : imm;
					end
					`DTBLC_CL_CALL: begin
						adv = 1'b0;
						sp_d = sp_q + 1'b1;
						stk_d[sp_d] = seq;
						pc_d = instr[27] ? dp_q[instr[26:24]] : imm;
					end
					`DTBLC_CL_RET, `DTBLC_CL_IRET: begin
						adv = 1'b0;
						pc_d = stk_q[sp_q];
						sp_d = sp_q - 1'b1;
						if (cls == `DTBLC_CL_IRET) ie_d = sie_q;
					end
					`DTBLC_CL_REP: begin
						rc_d = imm;
						rf_d = 1'b0;
					end
					`DTBLC_CL_LOOP: begin
						if (lsp_q < LPW'(LSD)) begin
							lstk_d[lsp_q[LPW-2:0]] = {lc_q, le_q, ls_q};
							lsp_d = lsp_q + 1'b1;
						end
						lc_d = imm;
						ls_d = seq;
						le_d = pc_q + {8'h00, instr[23:16]};
						rf_d = 1'b0;
					end
					`DTBLC_CL_LOOP_STACK_POP: if (lsp_q != '0) begin
						lsp_d = lsp_q - 1'b1;
						{lc_d, le_d, ls_d} = lstk_q[lsp_d[LPW-2:0]];
					end
					`DTBLC_CL_HALT: begin
						adv = 1'b0;
						pc_d = seq;
						st_d = DTBLC_HALT;
					end
					`DTBLC_CL_DISCARD_PENDING_INTERRUPT: discard_pending_interrupt_d = 1'b1;
					`DTBLC_CL_IEN:  ie_d = instr[0];
					default:        adv = 1'b1;
				endcase
				// repeat wins over loop end; the repeat word itself starts the count
				if (adv) begin
					if (rc_q != 16'h0000 && cls != `DTBLC_CL_REP) begin
						rc_d = rc_q - 16'h0001;
						if (rc_q == 16'h0001) begin
							pc_d = seq;
							rf_d = 1'b1;
						end
					end else if (lc_q != 16'h0000 && pc_q == le_q && cls != `DTBLC_CL_LOOP) begin
						lc_d = lc_q - 16'h0001;
						pc_d = (lc_q == 16'h0001) ? seq : ls_q;
						if (lc_q == 16'h0001) rf_d = 1'b1;
					end else begin
						pc_d = seq;
					end
				end
			end
			default: st_d = DTBLC_RUN;
		endcase
		if (take_irq) begin
			sp_d = sp_q + 1'b1;
			stk_d[sp_d] = pc_q;
			pc_d = irq_vec;
			sie_d = ie_q;
			ie_d = 1'b0;
			ack_d = 1'b1;
			st_d = DTBLC_RUN;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= DTBLC_RUN; pc_q <= `DTBLC_RST_PC; rc_q <= '0; lc_q <= '0;
			le_q <= '0; ls_q <= '0; sp_q <= '0; lsp_q <= '0; ie_q <= 1'b0;
			sie_q <= 1'b0; rf_q <= 1'b0; ack_q <= 1'b0; discard_pending_interrupt_q <= 1'b0;
			for (int i = 0; i < CSD; i++) stk_q[i] <= '0;
			for (int i = 0; i < LSD; i++) lstk_q[i] <= '0;
			for (int i = 0; i < 8; i++) begin
				dp_q[i] <= '0;
				dn_q[i] <= '0;
			end
			for (int s = 0; s < 2; s++) begin
				dm_q[s] <= `DTBLC_RST_DM; ma_q[s] <= '0; mwd_q[s] <= '0; mrd_q[s] <= 1'b0;
				mwr_q[s] <= 1'b0; gwe_q[s] <= 1'b0; gidx_q[s] <= '0; gpart_q[s] <= '0;
				gwd_q[s] <= '0;
			end
		end else begin
			st_q <= st_d; pc_q <= pc_d; rc_q <= rc_d; lc_q <= lc_d; le_q <= le_d;
			ls_q <= ls_d; sp_q <= sp_d; lsp_q <= lsp_d; ie_q <= ie_d; sie_q <= sie_d;
			rf_q <= rf_d; ack_q <= ack_d; discard_pending_interrupt_q <= discard_pending_interrupt_d; stk_q <= stk_d;
			lstk_q <= lstk_d; dp_q <= dp_d; dn_q <= dn_d; dm_q <= dm_d; ma_q <= ma_d;
			mwd_q <= mwd_d; mrd_q <= mrd_d; mwr_q <= mwr_d; gwe_q <= gwe_d;
			gidx_q <= gidx_d; gpart_q <= gpart_d; gwd_q <= gwd_d;
		end
	end

	assign prog_addr = pc_q;
	assign x_addr = ma_q[0];
	assign x_rd = mrd_q[0];
	assign x_wr = mwr_q[0];
	assign x_wdata = mwd_q[0];
	assign y_addr = ma_q[1];
	assign y_rd = mrd_q[1];
	assign y_wr = mwr_q[1];
	assign y_wdata = mwd_q[1];
	assign gx_we = gwe_q[0];
	assign gx_idx = gidx_q[0];
	assign gx_part = gpart_q[0];
	assign gx_wdata = gwd_q[0];
	assign gy_we = gwe_q[1];
	assign gy_idx = gidx_q[1];
	assign gy_part = gpart_q[1];
	assign gy_wdata = gwd_q[1];
	// halt is the only state code with bit 1 set
	assign halted = st_q[1];
	assign irq_ack = ack_q;
	assign discard_pending_interrupt = discard_pending_interrupt_q;
	assign repeat_done_flag = rf_q;

	// ****************************************
	// checks
	// ****************************************
	dtblc_word_t xdp_old;
	logic [2:0]  xpi, xpt;
	logic        ldx, stx, incx;
	assign xdp_old = dp_q[pidx[0]];
	assign xpi = pidx[0];
	assign xpt = fld[0][10:8];
	assign ldx = exec && cls == `DTBLC_CL_LDST && fld[0][12] && !fld[0][11] && xpt <= 3'h4;
	assign stx = exec && cls == `DTBLC_CL_LDST && fld[0][12] && fld[0][11];
	assign incx = exec && cls == `DTBLC_CL_LDST && fld[0][12] && fld[0][2:0] == 3'h1;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_pair_load: assert property (ldx |=> x_rd && st_q == DTBLC_LOAD ##1 gx_we && gx_idx == $past(gidx_q[0]))
		else $error("load not written back two cycles after issue");
	a_post_modify: assert property (incx |=> x_addr == $past(xdp_old) && dp_q[$past(xpi)] == $past(xdp_old) + 16'h0001)
		else $error("pointer access or post increment wrong");
	a_store_part: assert property (stx && (xpt < 3'h2 || xpt > 3'h4) |=> !x_wr)
		else $error("store from whole or ext+high not refused");
	a_trans_low: assert property (exec && cls == `DTBLC_CL_TRANS && instr[27] |=> gx_we && gx_part == 3'h4)
		else $error("transfer did not target the low half");
	a_imm_dp: assert property (exec && cls == `DTBLC_CL_IMM && instr[27:26] == 2'h1 |=> dp_q[$past(iidx)] == $past(imm))
		else $error("immediate not loaded into data pointer");
	a_dm_zero: assert property (exec && cls == `DTBLC_CL_IMM && instr[27:26] == 2'h3 && imm == 16'h0000 |=> $stable(dm_q[0]) && $stable(dm_q[1]))
		else $error("zero written to modulo range register");
	a_call_push: assert property (exec && cls == `DTBLC_CL_CALL |=> sp_q == $past(sp_q) + 1'b1 && stk_q[sp_q] == $past(pc_q) + 16'h0001)
		else $error("call did not push the next address");
	a_iret_ie: assert property (exec && cls == `DTBLC_CL_IRET |=> ie_q == $past(sie_q) && sp_q == $past(sp_q) - 1'b1 && pc_q == $past(stk_q[sp_q]))
		else $error("interrupt return did not restore state");
	a_rep_done: assert property (exec && rc_q == 16'h0001 && cls != `DTBLC_CL_REP |=> rc_q == 16'h0000 && rf_q && pc_q == $past(pc_q) + 16'h0001)
		else $error("repeat completion wrong");
	a_halt_hold: assert property (st_q == DTBLC_HALT && !(irq_req && ie_q) |=> halted && $stable(pc_q))
		else $error("halt left without enabled interrupt");
	a_loop_stack_pop_dec: assert property (exec && cls == `DTBLC_CL_LOOP_STACK_POP && lsp_q != '0 |=> lsp_q == $past(lsp_q) - 1'b1)
		else $error("loop pop did not drop the stack pointer");
endmodule // dtblc_core

// ---- sim/dtblc_mem_model.sv ----
`timescale 1ns/1ps
`include "dtblc_regs.svh"
// ********
// program memory, x/y data memories and register file
// ********
module dtblc_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] prog_addr,
	input  wire logic [15:0] x_addr,
	input  wire logic        x_rd,
	input  wire logic        x_wr,
	input  wire logic [15:0] x_wdata,
	input  wire logic [15:0] y_addr,
	input  wire logic        y_rd,
	input  wire logic        y_wr,
	input  wire logic [15:0] y_wdata,
	input  wire logic        gx_we,
	input  wire logic [2:0]  gx_idx,
	input  wire logic [2:0]  gx_part,
	input  wire logic [39:0] gx_wdata,
	input  wire logic        gy_we,
	input  wire logic [2:0]  gy_idx,
	input  wire logic [2:0]  gy_part,
	input  wire logic [39:0] gy_wdata,
	output logic      [31:0] instr,
	output logic             instr_valid,
	output logic      [39:0] gpr_x_rdata,
	output logic      [39:0] gpr_y_rdata,
	output logic      [15:0] x_rdata,
	output logic      [15:0] y_rdata
);
	logic [31:0] pm [0:65535];
	logic [15:0] xm [0:65535];
	logic [15:0] ym [0:65535];
	logic [39:0] rf [0:7];

	function automatic logic [39:0] part_mask(input logic [2:0] p);
		case (p)
			`DTBLC_PT_WHOLE: part_mask = 40'hFF_FFFF_FFFF;
			`DTBLC_PT_EXTHI: part_mask = 40'hFF_FFFF_0000;
			`DTBLC_PT_EXT:   part_mask = 40'hFF_0000_0000;
			`DTBLC_PT_HI:    part_mask = 40'h00_FFFF_0000;
			`DTBLC_PT_LO:    part_mask = 40'h00_0000_FFFF;
			default:         part_mask = 40'h00_0000_0000;
		endcase
	endfunction

	initial begin
		for (int i = 0; i < 65536; i++) begin
			pm[i] = 32'h0000_0000;
			xm[i] = 16'h0000;
			ym[i] = 16'h0000;
		end
		for (int i = 0; i < 8; i++) begin
			rf[i] = 40'h00_0000_0000;
		end
	end

	assign instr       = pm[prog_addr];
	assign instr_valid = 1'b1;
	function automatic logic [39:0] merge(input logic [39:0] o, input logic [2:0] p,
		input logic [39:0] d);
		merge = (o & ~part_mask(p)) | (d & part_mask(p));
	endfunction

	logic [2:0] gxa;
	assign gxa = (instr[31:28] == `DTBLC_CL_TRANS) ? instr[26:24] : instr[20:18];

	// write-through: the word after a load or transfer reads what lands at its own edge
	always_comb begin
		gpr_x_rdata = rf[gxa];
		gpr_y_rdata = rf[instr[7:5]];
		if (gx_we && gx_idx == gxa) gpr_x_rdata = merge(gpr_x_rdata, gx_part, gx_wdata);
		if (gy_we && gy_idx == gxa) gpr_x_rdata = merge(gpr_x_rdata, gy_part, gy_wdata);
		if (gx_we && gx_idx == instr[7:5]) gpr_y_rdata = merge(gpr_y_rdata, gx_part, gx_wdata);
		if (gy_we && gy_idx == instr[7:5]) gpr_y_rdata = merge(gpr_y_rdata, gy_part, gy_wdata);
	end
	// outside a read strobe the bus shows the inverse, so stale data never passes
	assign x_rdata     = x_rd ? xm[x_addr] : ~xm[x_addr];
	assign y_rdata     = y_rd ? ym[y_addr] : ~ym[y_addr];

	always @(posedge clk) begin
		if (x_wr) xm[x_addr] <= x_wdata;
		if (y_wr) ym[y_addr] <= y_wdata;
		if (gx_we) rf[gx_idx] <= (rf[gx_idx] & ~part_mask(gx_part)) | (gx_wdata & part_mask(gx_part));
		if (gy_we) rf[gy_idx] <= (rf[gy_idx] & ~part_mask(gy_part)) | (gy_wdata & part_mask(gy_part));
	end
endmodule // dtblc_mem_model

// ---- sim/dsp_transfer_branch_loop_control_tb_top.sv ----
`timescale 1ns/1ps
`include "dtblc_regs.svh"
module dsp_transfer_branch_loop_control_tb_top;
	logic        clk, rstn, irq_req, instr_valid, x_rd, x_wr, y_rd, y_wr, gx_we, gy_we;
	logic        halted, irq_ack, discard_pending_interrupt, repeat_done_flag;
	logic [15:0] irq_vec, x_rdata, y_rdata, prog_addr, x_addr, x_wdata, y_addr, y_wdata;
	logic [31:0] instr;
	logic [39:0] gpr_x_rdata, gpr_y_rdata, gx_wdata, gy_wdata;
	logic [2:0]  gx_idx, gx_part, gy_idx, gy_part;
	logic [12:0] idle_f;
	logic [32:0] rows [0:21];
	int          miscompares, check_count;

	dtblc_core #(.CSD(16), .LSD(4)) i_dut (
		.clk(clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid),
		.gpr_x_rdata(gpr_x_rdata), .gpr_y_rdata(gpr_y_rdata), .x_rdata(x_rdata),
		.y_rdata(y_rdata), .irq_req(irq_req), .irq_vec(irq_vec), .prog_addr(prog_addr),
		.x_addr(x_addr), .x_rd(x_rd), .x_wr(x_wr), .x_wdata(x_wdata), .y_addr(y_addr),
		.y_rd(y_rd), .y_wr(y_wr), .y_wdata(y_wdata), .gx_we(gx_we), .gx_idx(gx_idx),
		.gx_part(gx_part), .gx_wdata(gx_wdata), .gy_we(gy_we), .gy_idx(gy_idx),
		.gy_part(gy_part), .gy_wdata(gy_wdata), .halted(halted), .irq_ack(irq_ack),
		.discard_pending_interrupt(discard_pending_interrupt),
		.repeat_done_flag(repeat_done_flag));

	dtblc_mem_model i_mem (
		.clk(clk), .prog_addr(prog_addr), .x_addr(x_addr), .x_rd(x_rd), .x_wr(x_wr),
		.x_wdata(x_wdata), .y_addr(y_addr), .y_rd(y_rd), .y_wr(y_wr), .y_wdata(y_wdata),
		.gx_we(gx_we), .gx_idx(gx_idx), .gx_part(gx_part), .gx_wdata(gx_wdata),
		.gy_we(gy_we), .gy_idx(gy_idx), .gy_part(gy_part), .gy_wdata(gy_wdata),
		.instr(instr), .instr_valid(instr_valid), .gpr_x_rdata(gpr_x_rdata),
		.gpr_y_rdata(gpr_y_rdata), .x_rdata(x_rdata), .y_rdata(y_rdata));

	// ********
	// encoders, checking and closing
	// ********
	function automatic logic [12:0] fs(input int st, input int pt, input int g, input int pr,
		input int md);
		fs = {1'b1, st[0], pt[2:0], g[2:0], pr[1:0], md[2:0]};
	endfunction
	function automatic logic [31:0] ls(input logic [12:0] x, input logic [12:0] y);
		ls = {`DTBLC_CL_LDST, 2'h0, x, y};
	endfunction
	function automatic logic [31:0] im(input int t, input int i, input logic [15:0] v);
		im = {`DTBLC_CL_IMM, t[1:0], i[2:0], 7'h00, v};
	endfunction
	function automatic logic [31:0] op(input logic [3:0] c, input logic [15:0] v);
		op = {c, 12'h000, v};
	endfunction
	function automatic logic [31:0] tr(input int d, input int g, input int s);
		tr = {`DTBLC_CL_TRANS, d[0], g[2:0], s[4:0], 19'h00000};
	endfunction
	task automatic p(input int a, input logic [31:0] w);
		i_mem.pm[a[15:0]] = w;
	endtask

	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// waits on halted (0) or irq_ack (1), sampled mid-cycle
	task automatic wait_until(input int which);
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			if ((which != 0 ? irq_ack : halted) === 1'b1) break;
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// run needs well under 200 cycles; a hang counts against the run
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		$display("watchdog expired");
		results();
	end

	initial begin
		rstn = 1'b0;
		irq_req = 1'b0;
		irq_vec = 16'h0000;
		idle_f = 13'h0000;
		miscompares = 0;
		check_count = 0;
		#1;
		p(0, im(0, 0, 16'hA5C3));
		p(1, im(0, 1, 16'hFFFF));
		p(2, im(1, 0, 16'h0010));
		p(3, im(2, 0, 16'h0003));
		p(4, im(1, 4, 16'h0020));
		p(5, im(1, 1, 16'h0001));
		p(6, im(2, 1, 16'h0002));
		p(7, ls(fs(1, 4, 0, 0, 1), fs(1, 4, 1, 0, 2)));
		p(8, ls(fs(1, 4, 0, 0, 3), idle_f));
		p(9, ls(fs(1, 4, 1, 0, 0), idle_f));
		// whole-register store is refused but still steps the pointer
		p(10, ls(fs(1, 0, 0, 0, 1), idle_f));
		p(11, ls(fs(1, 4, 0, 0, 1), idle_f));
		p(12, ls(idle_f, fs(0, 4, 2, 0, 0)));
		p(13, ls(fs(1, 4, 2, 0, 1), idle_f));
		p(14, op(`DTBLC_CL_CALL, 16'h0040));
		p(15, ls(fs(1, 4, 0, 0, 1), idle_f));
		p(16, op(`DTBLC_CL_REP, 16'h0003));
		p(17, ls(fs(1, 4, 0, 0, 1), idle_f));
		p(18, tr(0, 1, 8));
		p(19, tr(1, 4, 8));
		p(20, ls(fs(1, 4, 4, 0, 1), idle_f));
		p(21, ls(fs(1, 4, 0, 1, 5), idle_f));
		p(22, ls(fs(1, 4, 1, 1, 0), idle_f));
		p(23, ls(fs(0, 0, 5, 2, 0), idle_f));
		p(24, ls(fs(1, 3, 5, 0, 1), idle_f));
		p(25, ls(fs(1, 4, 5, 0, 1), idle_f));
		p(26, op(`DTBLC_CL_IEN, 16'h0001));
		p(27, op(`DTBLC_CL_HALT, 16'h0000));
		p(28, ls(fs(1, 4, 0, 0, 1), idle_f));
		p(29, op(`DTBLC_CL_HALT, 16'h0000));
		p(30, op(`DTBLC_CL_HALT, 16'h0000));
		p(31, im(3, 0, 16'h0000));
		p(32, tr(1, 6, 16));
		p(33, op(`DTBLC_CL_LOOP, 16'h0002) | 32'h0001_0000);
		p(34, ls(fs(1, 4, 6, 0, 1), idle_f));
		p(35, op(`DTBLC_CL_LOOP_STACK_POP, 16'h0000));
		p(36, op(`DTBLC_CL_HALT, 16'h0000));
		p(64, ls(fs(1, 4, 1, 0, 1), idle_f));
		p(65, op(`DTBLC_CL_RET, 16'h0000));
		p(96, op(`DTBLC_CL_DISCARD_PENDING_INTERRUPT, 16'h0000));
		p(97, op(`DTBLC_CL_IRET, 16'h0000));
		i_mem.ym[16'h001F] = 16'h1234;
		i_mem.xm[16'h0000] = 16'h1234;
		i_mem.xm[16'h001E] = 16'hBEEF;
		rows = '{{1'b0, 16'h0010, 16'hA5C3}, {1'b1, 16'h0020, 16'hFFFF},
			{1'b0, 16'h0011, 16'hA5C3}, {1'b0, 16'h0012, 16'h0000}, {1'b0, 16'h0014, 16'hFFFF},
			{1'b0, 16'h0015, 16'hA5C3}, {1'b0, 16'h0016, 16'h1234}, {1'b0, 16'h0017, 16'hFFFF},
			{1'b0, 16'h0018, 16'hA5C3}, {1'b0, 16'h0019, 16'hA5C3}, {1'b0, 16'h001A, 16'hA5C3},
			{1'b0, 16'h001B, 16'hA5C3}, {1'b0, 16'h001C, 16'hFFFF}, {1'b0, 16'h8000, 16'hA5C3},
			{1'b0, 16'h0001, 16'h0000}, {1'b0, 16'h0003, 16'hFFFF}, {1'b0, 16'h001D, 16'h1234},
			{1'b0, 16'h001E, 16'h0000}, {1'b0, 16'h001F, 16'hA5C3}, {1'b0, 16'h0020, 16'hFFFF},
			{1'b0, 16'h0021, 16'hFFFF}, {1'b0, 16'h0022, 16'h0000}};
		repeat (7) @(posedge clk);
		@(negedge clk);
		check({prog_addr, x_wr, y_wr, gx_we, gy_we, halted, irq_ack, repeat_done_flag}, 40'h0,
			"reset outputs");
		@(posedge clk);
		rstn <= 1'b1;
		$display("test reset done");
		wait_until(0);
		check(prog_addr, 16'h001C, "halt address");
		repeat (5) @(negedge clk);
		check({halted, prog_addr}, {1'b1, 16'h001C}, "halt holds");
		@(posedge clk);
		irq_vec <= 16'h0060;
		irq_req <= 1'b1;
		wait_until(1);
		check({halted, prog_addr}, {1'b0, 16'h0060}, "wake vector");
		@(posedge clk);
		irq_req <= 1'b0;
		@(negedge clk);
		check(discard_pending_interrupt, 1'b1, "discard pulse");
		$display("test halt wake done");
		wait_until(0);
		check(prog_addr, 16'h001E, "return address");
		@(posedge clk);
		irq_req <= 1'b1;
		wait_until(1);
		check(prog_addr, 16'h0060, "enable restored");
		@(posedge clk);
		irq_req <= 1'b0;
		wait_until(0);
		check(prog_addr, 16'h001F, "second return");
		$display("test interrupt return done");
		@(posedge clk);
		irq_req <= 1'b1;
		wait_until(1);
		@(posedge clk);
		irq_req <= 1'b0;
		wait_until(0);
		check(prog_addr, 16'h0025, "loop and pop end");
		$display("test loop done");
		for (int i = 0; i < 22; i++) begin
			check(rows[i][32] ? i_mem.ym[rows[i][31:16]] : i_mem.xm[rows[i][31:16]],
				rows[i][15:0], $sformatf("memory word %h", rows[i][31:16]));
		end
		check(repeat_done_flag, 1'b1, "repeat flag");
		$display("test memory image done");
		results();
	end
endmodule // dsp_transfer_branch_loop_control_tb_top
